// file: logic/ebpt_pkg.sv
package ebpt_pkg;

  // ==========================================================
  // Register map and geometry
  // ==========================================================
  localparam int          NUM_CS       = 4;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          DIV_W        = 8;
  localparam logic [7:0]  OFS_TCON0    = 8'h00;
  localparam logic [7:0]  OFS_CTRL     = 8'h10;
  localparam logic [7:0]  OFS_STATUS   = 8'h14;
  localparam logic [15:0] TCON_RESET   = 16'h0000;
  localparam logic [7:0]  DIV_RESET    = 8'h00;

  // ==========================================================
  // Timing control field positions
  // ==========================================================
  localparam int F_AB       = 0;
  localparam int F_CMD_LO   = 1;
  localparam int F_CMD_HI   = 2;
  localparam int F_WS       = 3;
  localparam int F_ACC_LO   = 4;
  localparam int F_ACC_HI   = 8;
  localparam int F_HOLD_LO  = 9;
  localparam int F_HOLD_HI  = 10;
  localparam int F_RDY_EN   = 11;
  localparam int F_WIN_LO   = 12;
  localparam int F_WIN_HI   = 13;
  localparam int TCON_W     = 14;

  localparam int          CNT_W    = 5;
  localparam logic [4:0]  CNT_ZERO = 5'h00;
  localparam logic [4:0]  AB_MAX   = 5'h04;
  localparam logic [4:0]  HOLD_MAX = 5'h02;

  // Phases of one external bus cycle.
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_AB,
    PH_C,
    PH_D,
    PH_E,
    PH_F
  } ebpt_phase_t;

  typedef struct packed {
    ebpt_phase_t      ph;
    logic [CNT_W-1:0] cnt;
  } ebpt_step_t;

endpackage

// file: logic/ebpt_tick_div.sv
`timescale 1ns/1ps
module ebpt_tick_div
  import ebpt_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] period_i,
  output logic              tick_o
);

  // ==========================================================
  // Timing cycle divider
  // ==========================================================
  // A period of N gives one tick every N+1 system clocks.
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    if (cnt_q >= period_i) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_o = (cnt_q >= period_i);

endmodule

// file: logic/ebpt_phase_timer.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Bus cycles run setup, command, write setup, access, hold in that order.
// - Lengths come from the selected chip select's timing; command is 0 to 3.
// - With ready enabled, access lasts until the far side drives ready.
// - Address setup is 1 or 2 cycles plus 0 to 3 on window change, at most 5.
// - Write setup or tristate lasts 0 or 1 timing cycle.
// - Access lasts 1 to 32 timing cycles before any ready extension.
// - Hold lasts 0 to 3 timing cycles.
module ebpt_phase_timer
  import ebpt_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              req_i,
  input  wire logic [1:0]        req_cs_i,
  input  wire logic              req_win_change_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic      [2:0]        phase_o,
  input  wire logic              ready_i
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [NUM_CS-1:0][TCON_W-1:0] tcon;
    logic [DIV_W-1:0]              div;
    logic [TCON_W-1:0]             lat;
    logic                          win;
    ebpt_phase_t                   ph;
    logic [CNT_W-1:0]              cnt;
    logic                          done;
    logic                          rdy_m;
    logic                          rdy_s;
    logic [DATA_W-1:0]             rdata;
  } ebpt_state_t;

  ebpt_state_t s_q;
  ebpt_state_t s_d;
  logic        tick;

  ebpt_tick_div #(.W(DIV_W)) u_div (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .period_i  (s_q.div),
    .tick_o    (tick)
  );

  // ==========================================================
  // Phase sequencing
  // ==========================================================
  // Works out which phase follows a finished one, skipping zero lengths.
  function automatic ebpt_step_t next_step(input ebpt_phase_t from,
                                           input logic [TCON_W-1:0] t);
    ebpt_step_t r;
    r.ph  = PH_IDLE;
    r.cnt = CNT_ZERO;
    if (from == PH_AB && t[F_CMD_HI:F_CMD_LO] != 2'h0) begin
      r.ph  = PH_C;
      r.cnt = CNT_W'(t[F_CMD_HI:F_CMD_LO]) - CNT_W'(1);
    end else if ((from == PH_AB || from == PH_C) && t[F_WS]) begin
      r.ph  = PH_D;
      r.cnt = CNT_ZERO;
    end else if (from == PH_AB || from == PH_C || from == PH_D) begin
      r.ph  = PH_E;
      r.cnt = CNT_W'(t[F_ACC_HI:F_ACC_LO]);
    end else if (from == PH_E && t[F_HOLD_HI:F_HOLD_LO] != 2'h0) begin
      r.ph  = PH_F;
      r.cnt = CNT_W'(t[F_HOLD_HI:F_HOLD_LO]) - CNT_W'(1);
    end
    return r;
  endfunction

  logic [TCON_W-1:0] sel_tcon;
  ebpt_step_t        nxt;
  logic [CNT_W-1:0]  ab_len;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    // Only the second stage is read; the first just settles the pin.
    s_d.rdy_m = ready_i;
    s_d.rdy_s = s_q.rdy_m;
    sel_tcon = s_q.tcon[req_cs_i];
    nxt      = next_step(s_q.ph, s_q.lat);
    ab_len   = CNT_W'(sel_tcon[F_AB]);
    if (req_win_change_i) begin
      ab_len = ab_len + CNT_W'(sel_tcon[F_WIN_HI:F_WIN_LO]);
    end
    unique case (s_q.ph)
      PH_IDLE: begin
        if (req_i) begin
          s_d.lat = sel_tcon;
          s_d.win = req_win_change_i;
          s_d.ph  = PH_AB;
          s_d.cnt = ab_len;
        end
      end
      PH_E: begin
        if (tick) begin
          if (s_q.cnt != CNT_ZERO) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end else if (!s_q.lat[F_RDY_EN] || s_q.rdy_s) begin
            s_d.ph   = nxt.ph;
            s_d.cnt  = nxt.cnt;
            s_d.done = (nxt.ph == PH_IDLE);
          end
        end
      end
      default: begin
        if (tick) begin
          if (s_q.cnt != CNT_ZERO) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end else begin
            s_d.ph   = nxt.ph;
            s_d.cnt  = nxt.cnt;
            s_d.done = (nxt.ph == PH_IDLE);
          end
        end
      end
    endcase

    // ========================================================
    // Register port
    // ========================================================
    s_d.rdata = '0;
    if (reg_wr_i) begin
      for (int i = 0; i < NUM_CS; i++) begin
        if (reg_addr_i == OFS_TCON0 + ADDR_W'(4 * i)) begin
          s_d.tcon[i] = reg_wdata_i[TCON_W-1:0];
        end
      end
      if (reg_addr_i == OFS_CTRL) begin
        s_d.div = reg_wdata_i[DIV_W-1:0];
      end
    end
    if (reg_rd_i) begin
      for (int i = 0; i < NUM_CS; i++) begin
        if (reg_addr_i == OFS_TCON0 + ADDR_W'(4 * i)) begin
          s_d.rdata = DATA_W'(s_q.tcon[i]);
        end
      end
      if (reg_addr_i == OFS_CTRL) begin
        s_d.rdata = DATA_W'(s_q.div);
      end
      if (reg_addr_i == OFS_STATUS) begin
        s_d.rdata = DATA_W'({s_q.rdy_s, s_q.cnt, 1'(s_q.ph != PH_IDLE),
                             3'(s_q.ph)});
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q       <= '0;
      s_q.tcon  <= {NUM_CS{TCON_RESET[TCON_W-1:0]}};
      s_q.div   <= DIV_RESET;
      s_q.ph    <= PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Data outputs come straight from the state register.
  assign reg_rdata_o = s_q.rdata;
  assign busy_o      = (s_q.ph != PH_IDLE);
  assign done_o      = s_q.done;
  assign phase_o     = 3'(s_q.ph);

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_phase_order: assert property (
    s_q.ph == PH_AB |=> s_q.ph inside {PH_AB, PH_C, PH_D, PH_E})
    else $error("Address setup left to an illegal phase.");
  chk_cs_select: assert property (
    s_q.ph == PH_IDLE && req_i |=> s_q.lat == $past(s_q.tcon[req_cs_i]))
    else $error("Wrong chip select timing latched.");
  chk_ready_wait: assert property (
    s_q.ph == PH_E && s_q.cnt == CNT_ZERO && s_q.lat[F_RDY_EN]
    && !s_q.rdy_s |=> s_q.ph == PH_E)
    else $error("Access ended without ready.");
  chk_ab_bound: assert property (
    s_q.ph == PH_AB |-> s_q.cnt <= AB_MAX)
    else $error("Address setup longer than five cycles.");
  chk_dsetup_one: assert property (
    s_q.ph == PH_D |-> s_q.cnt == CNT_ZERO)
    else $error("Write setup longer than one cycle.");
  chk_access_load: assert property (
    s_q.ph != PH_E ##1 s_q.ph == PH_E
    |-> s_q.cnt == CNT_W'(s_q.lat[F_ACC_HI:F_ACC_LO]))
    else $error("Access length not loaded.");
  chk_hold_bound: assert property (
    s_q.ph == PH_F |-> s_q.cnt <= HOLD_MAX)
    else $error("Hold longer than three cycles.");
  chk_tick_step: assert property (
    $past(s_q.ph) != PH_IDLE && $changed(s_q.ph) |-> $past(tick))
    else $error("Phase changed between timing cycles.");
  chk_cmd_skip: assert property (
    s_q.ph == PH_AB && s_q.lat[F_CMD_HI:F_CMD_LO] == 2'h0
    |=> s_q.ph != PH_C)
    else $error("Zero command delay not skipped.");

  cov_ready_wait: cover property (
    s_q.ph == PH_E && s_q.lat[F_RDY_EN] && !s_q.rdy_s ##1 s_q.ph == PH_E);
  cov_full_cycle: cover property (s_q.ph == PH_F ##1 s_q.ph == PH_IDLE);
  cov_win_change: cover property (
    s_q.ph == PH_IDLE && req_i && req_win_change_i);

endmodule

// file: bench/ebpt_ext_device.sv
`timescale 1ns/1ps
module ebpt_ext_device (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] phase_i,
  input  wire logic [7:0] wait_i,
  output logic            ready_o
);
  // ==========================================================
  // Ready handshake of the external module
  // ==========================================================
  logic [7:0] acc_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= 8'h00;
    end else if (phase_i == 3'h4) begin
      acc_q <= acc_q + 8'h01;
    end else begin
      acc_q <= 8'h00;
    end
  end

  // Ready is a level, dropped as soon as the access is over.
  assign ready_o = (phase_i == 3'h4) && (acc_q >= wait_i);
endmodule

// file: bench/ebpt_phase_timer_tb.sv
`timescale 1ns/1ps
module ebpt_phase_timer_tb;
  import ebpt_pkg::*;
  // ==========================================================
  // Signals and instances
  // ==========================================================
  logic              ref_clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic              req_i = 1'b0;
  logic [1:0]        req_cs_i = 2'h0;
  logic              req_win_change_i = 1'b0;
  logic              busy_o;
  logic              done_o;
  logic [2:0]        phase_o;
  logic              ready_i;
  logic [7:0]        dev_wait = 8'h00;
  logic [13:0]       tc [4];
  logic [13:0]       tab [5] = '{14'h0000, 14'h37FF, 14'h2202, 14'h1455,
                                 14'h0008};
  int                error_cnt, samples_checked, cycles, div;
  int                cnt [6];

  always #12.5 ref_clk_i = ~ref_clk_i;

  ebpt_phase_timer u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .req_i(req_i), .req_cs_i(req_cs_i),
    .req_win_change_i(req_win_change_i), .busy_o(busy_o),
    .done_o(done_o), .phase_o(phase_o), .ready_i(ready_i));

  ebpt_ext_device u_dev (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .phase_i(phase_o), .wait_i(dev_wait), .ready_o(ready_i));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("rdata", reg_rdata_o, e);
  endtask

  task automatic set_t(logic [1:0] cs, logic [13:0] t);
    tc[cs] = t;
    wr(OFS_TCON0 + 8'({cs, 2'b00}), {18'h0, t});
  endtask

  // Runs one bus cycle and counts the clocks spent in each phase.
  task automatic cyc(logic [1:0] cs, logic wc, logic dbl, int nx);
    logic [13:0] t;
    int          m, tot, n, last, ab;
    t = tc[cs];
    m = div + 1;
    tot = 2 + t[F_AB] + t[F_CMD_HI:F_CMD_LO] + t[F_WS]
          + t[F_ACC_HI:F_ACC_LO] + t[F_HOLD_HI:F_HOLD_LO];
    ab = 1 + t[F_AB] + (wc ? t[F_WIN_HI:F_WIN_LO] : 0);
    cnt = '{default: 0};
    last = 1;
    n = 0;
    if (req_i !== 1'b1) begin
      @(posedge ref_clk_i);
      req_cs_i <= cs;
      req_win_change_i <= wc;
      req_i <= 1'b1;
    end
    @(posedge ref_clk_i);
    if (!dbl) req_i <= 1'b0;
    while (n < 300) begin
      #1;
      if (done_o === 1'b1) break;
      chk("order", phase_o >= last && phase_o < 6, 1);
      if (phase_o < 6) last = phase_o;
      if (phase_o < 6) cnt[phase_o]++;
      n++;
      @(posedge ref_clk_i);
      if (nx >= 0 && n == tot) begin
        req_cs_i <= 2'(nx);
        req_win_change_i <= 1'b0;
        req_i <= 1'b1;
      end else begin
        // A held request must be ignored for the whole busy stretch.
        req_i <= dbl;
      end
    end
    chk("done", done_o, 1);
    if (div == 0) chk("addr", cnt[1], ab);
    chk("cmd", cnt[2], m * t[F_CMD_HI:F_CMD_LO]);
    chk("wsetup", cnt[3], m * t[F_WS]);
    if (!t[F_RDY_EN]) begin
      chk("access", cnt[4], m * (t[F_ACC_HI:F_ACC_LO] + 1));
    end
    chk("hold", cnt[5], m * t[F_HOLD_HI:F_HOLD_LO]);
    if (dbl) begin
      req_i <= 1'b0;
      @(posedge ref_clk_i);
      #1 chk("refused", busy_o, 0);
    end
  endtask

  // A run still going after 5000 clocks is stopped here and counted as a mismatch.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd(OFS_TCON0, {16'h0, TCON_RESET});
    rd(OFS_CTRL, {24'h0, DIV_RESET});
    rd(OFS_STATUS, 0);
    wr(8'h20, 32'hFFFF_FFFF);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(8'h20, 0);
    rd(OFS_STATUS, 0);
    for (int i = 0; i < 4; i++) set_t(2'(i), 14'h3FFF - 14'(i));
    for (int i = 0; i < 4; i++) begin
      rd(OFS_TCON0 + 8'(4 * i), 32'h3FFF - i);
    end
    foreach (tab[i]) begin
      set_t(2'(i), tab[i]);
      cyc(2'(i), i[0], 1'b0, -1);
    end
    set_t(1, 14'h0012);
    set_t(2, 14'h0204);
    cyc(1, 1'b0, 1'b1, -1);
    cyc(1, 1'b0, 1'b0, 2);
    cyc(2, 1'b0, 1'b0, -1);
    div = 1;
    wr(OFS_CTRL, 32'h0000_0001);
    set_t(0, 14'h0222);
    cyc(0, 1'b0, 1'b0, -1);
    div = 0;
    wr(OFS_CTRL, 32'h0000_0000);
    set_t(3, 14'h0830);
    cyc(3, 1'b0, 1'b0, -1);
    chk("ready_fast", cnt[4], 4);
    set_t(3, 14'h0800);
    dev_wait = 8'h06;
    cyc(3, 1'b0, 1'b0, -1);
    chk("ready_slow", cnt[4] >= 7 && cnt[4] <= 10, 1);
    stop_test();
  end
endmodule
